// file: core/adcsc_pkg.sv
// constants, register map and types of the system calibration sequencer
package adcsc_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [7:0] ADDR_SETUP  = 8'h00;
    localparam logic [7:0] ADDR_RATE   = 8'h04;
    localparam logic [7:0] ADDR_DATA   = 8'h08;
    localparam logic [7:0] ADDR_ZCOEF  = 8'h0c;
    localparam logic [7:0] ADDR_FCOEF  = 8'h10;
    localparam logic [7:0] ADDR_STAT   = 8'h14;
    localparam logic [7:0] ADDR_MASK   = 8'h18;
    // ==========================================================
    // setup register fields
    localparam int SETUP_LO_POS  = 0;
    localparam int SETUP_HI_POS  = 1;
    localparam int SETUP_BIP_POS = 2;
    // calibration mode codes {hi, lo}
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_SELF    = 2'h1;
    localparam logic [1:0] MODE_SYS_ZS  = 2'h2;
    localparam logic [1:0] MODE_SYS_FS  = 2'h3;
    // ==========================================================
    // status and mask bits
    localparam int STAT_CAL_POS  = 0;
    localparam int STAT_DATA_POS = 1;
    localparam int STAT_W        = 2;
    // ==========================================================
    // reset values
    localparam logic [15:0] RATE_RST  = 16'h1000;
    localparam logic [15:0] ZCOEF_RST = 16'h0000;
    localparam logic [15:0] FCOEF_RST = 16'hffff;
    localparam logic [15:0] MIDSCALE  = 16'h8000;
    // ==========================================================
    // timing: one modulator cycle is 128 master clocks
    localparam int MOD_DIV       = 128;
    localparam int CAL_PERIODS   = 3;
    localparam logic [1:0] LAST_STEP = 2'(CAL_PERIODS - 1);
    // analog front end input selection
    localparam logic [1:0] SEL_EXT   = 2'h0;
    localparam logic [1:0] SEL_SHORT = 2'h1;
    localparam logic [1:0] SEL_REF   = 2'h2;
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE, ST_SYS_ZS, ST_SYS_FS, ST_SELF_ZS, ST_SELF_FS, ST_POST
    } adcsc_fsm_e;
endpackage : adcsc_pkg

// file: core/adcsc_top.sv
// system calibration sequencer with apb register file
`timescale 1ns/1ps
// ==========================================================
// register map, one aligned 32-bit word each
// 0x00 setup: [1:0] calibration mode {hi, lo}, [2] bipolar
// 0x04 rate: master clocks per output period, 0 acts as 1
// 0x08 data: last conversion word, a read frees the ready line
// 0x0c zero coefficient, 0x10 full coefficient, both writable
// 0x14 status: [0] calibration done, [1] new data word, read clears
// 0x18 mask: same layout as status, drives the irq level
// the upper address bits must be zero to hit a register
// other addresses answer with pslverr and have no effect
//
// ==========================================================
// sequencer timing, from the edge that takes the mode write
// zero or full system step: three periods, then mode reads zero
// one more period of normal conversion, then the ready line falls
// self calibration: three periods shorted, three on the reference
// a mode write of zero during a step aborts back to normal
// a new calibration command restarts the period counter
//
// ==========================================================
// hazards and limits
// the modulator tick is free running, so the raise of a low ready
// line can lag the command by up to one modulator cycle
// the full coefficient is only stored, no gain math is applied
// a status event in the cycle of a status read stays set
// apb answers after exactly one wait state, pready lasts one cycle
// the period counter is compared with >= so a rate written below
// the running count ends the period at once instead of wrapping
// the step counter only advances while a calibration step runs
// the post state holds one conversion period before data loads
// a zero coefficient loaded by a step takes effect on the next result
// the bipolar bit only moves the zero point to midscale
// the data read and the period tick may meet in one cycle:
// the tick loads a fresh word and pulls ready low again
// the analog select output follows the step: external for
// system steps, shorted then reference for self calibration
// a write to data or status is ignored without an error
// reset loads nominal coefficients: zero offset, full scale
// reset holds the ready line high until the first conversion
module adcsc_top
    import adcsc_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic [DATA_W-1:0] modulator_code,
    output logic [1:0]             analog_input_pair_sel,
    output logic                   conversion_ready_low,
    output logic                   irq
);

    // ==========================================================
    // state
    typedef struct packed {
        // register file
        logic [1:0]        mode;
        logic              bipolar;
        logic [15:0]       rate;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] zcoef;
        logic [DATA_W-1:0] fcoef;
        logic [STAT_W-1:0] stat;
        logic [STAT_W-1:0] mask;
        // sequencer and dividers
        adcsc_fsm_e        fsm;
        logic [15:0]       per_cnt;
        logic [6:0]        mod_cnt;
        logic [1:0]        steps;
        logic              raise_pend;
        logic              rdy_n;
        logic [1:0]        sel;
        // bus answer and interrupt
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
        logic              irq;
    } adcsc_state_s;

    adcsc_state_s s_reg;
    adcsc_state_s s_next;

    // decoded bus strobes
    logic              access;
    logic              wr;
    logic              rd;
    logic              mapped;
    logic [7:0]        addr;
    // timing strobes and sequencer events
    logic              per_tick;
    logic              mod_tick;
    logic              cal_cmd;
    logic              step_end;
    logic [DATA_W-1:0] result;
    logic [STAT_W-1:0] ev;

    // ==========================================================
    // bus decode and period dividers
    assign addr     = paddr[7:0];
    assign access   = psel & penable & s_reg.pready;
    assign wr       = access & pwrite;
    assign rd       = access & ~pwrite;
    assign mapped   = (paddr[31:8] == 24'h000000) && (addr[1:0] == 2'h0) && (addr <= ADDR_MASK);
    assign per_tick = ({1'b0, s_reg.per_cnt} + 17'h00001) >= {1'b0, s_reg.rate};
    assign mod_tick = s_reg.mod_cnt == 7'(MOD_DIV - 1);
    assign cal_cmd  = wr & mapped & (addr == ADDR_SETUP) & (pwdata[SETUP_HI_POS:SETUP_LO_POS] != MODE_NORMAL);
    assign step_end = per_tick & (s_reg.steps == LAST_STEP);

    // conversion result, zero point at midscale when bipolar
    always_comb begin
        result = modulator_code - s_reg.zcoef;
        if (s_reg.bipolar) begin
            result = result + MIDSCALE[DATA_W-1:0];
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        s_next = s_reg;
        ev     = '0;

        // apb slave: one wait cycle, then answer
        s_next.pready = psel & penable & ~s_reg.pready;
        s_next.pslverr = 1'b0;
        if (psel & penable & ~s_reg.pready) begin
            s_next.pslverr = ~mapped;
            // reads of other low address bytes return zero, upper address bits are not decoded here
            s_next.prdata  = 32'h00000000;
            if (addr == ADDR_SETUP) begin
                s_next.prdata[SETUP_HI_POS:SETUP_LO_POS] = s_reg.mode;
                s_next.prdata[SETUP_BIP_POS] = s_reg.bipolar;
            end else if (addr == ADDR_RATE) begin
                s_next.prdata[15:0] = s_reg.rate;
            end else if (addr == ADDR_DATA) begin
                s_next.prdata[DATA_W-1:0] = s_reg.data;
            end else if (addr == ADDR_ZCOEF) begin
                s_next.prdata[DATA_W-1:0] = s_reg.zcoef;
            end else if (addr == ADDR_FCOEF) begin
                s_next.prdata[DATA_W-1:0] = s_reg.fcoef;
            end else if (addr == ADDR_STAT) begin
                s_next.prdata[STAT_W-1:0] = s_reg.stat;
            end else if (addr == ADDR_MASK) begin
                s_next.prdata[STAT_W-1:0] = s_reg.mask;
            end
        end

        // dividers
        s_next.mod_cnt = mod_tick ? 7'h00 : s_reg.mod_cnt + 7'h01;
        s_next.per_cnt = per_tick ? 16'h0000 : s_reg.per_cnt + 16'h0001;
        if (per_tick && s_reg.fsm != ST_IDLE && s_reg.fsm != ST_POST) begin
            s_next.steps = s_reg.steps + 2'h1;
        end

        // register writes
        if (wr && mapped) begin
            if (addr == ADDR_SETUP) begin
                s_next.mode    = pwdata[SETUP_HI_POS:SETUP_LO_POS];
                s_next.bipolar = pwdata[SETUP_BIP_POS];
                if (!cal_cmd) begin
                    s_next.fsm = ST_IDLE; // normal mode ends any step
                    s_next.sel = SEL_EXT;
                end
            end else if (addr == ADDR_RATE) begin
                s_next.rate = pwdata[15:0];
            end else if (addr == ADDR_ZCOEF) begin
                s_next.zcoef = pwdata[DATA_W-1:0];
            end else if (addr == ADDR_FCOEF) begin
                s_next.fcoef = pwdata[DATA_W-1:0];
            end else if (addr == ADDR_MASK) begin
                s_next.mask = pwdata[STAT_W-1:0];
            end
        end

        // reading the data word frees the ready line
        if (rd && mapped && addr == ADDR_DATA) begin
            s_next.rdy_n = 1'b1;
        end

        // sequencer
        if (cal_cmd) begin
            s_next.per_cnt = 16'h0000;
            s_next.steps   = 2'h0;
            s_next.raise_pend = ~s_reg.rdy_n;
            case (pwdata[SETUP_HI_POS:SETUP_LO_POS])
                // zero-scale step on the external input
                MODE_SYS_ZS: begin
                    s_next.fsm = ST_SYS_ZS;
                    s_next.sel = SEL_EXT;
                end
                // full-scale step on the external input
                MODE_SYS_FS: begin
                    s_next.fsm = ST_SYS_FS;
                    s_next.sel = SEL_EXT;
                end
                // self calibration starts on shorted inputs
                default: begin
                    s_next.fsm = ST_SELF_ZS;
                    s_next.sel = SEL_SHORT;
                end
            endcase
        end else begin
            case (s_reg.fsm)
                // normal conversions, one word per period
                ST_IDLE: begin
                    if (per_tick) begin
                        s_next.data  = result;
                        s_next.rdy_n = 1'b0;
                        ev[STAT_DATA_POS] = 1'b1;
                    end
                end
                // system zero step, offset coefficient at its end
                ST_SYS_ZS: begin
                    if (step_end) begin
                        s_next.zcoef = modulator_code;
                        s_next.mode  = MODE_NORMAL;
                        s_next.fsm   = ST_POST;
                        ev[STAT_CAL_POS] = 1'b1;
                    end
                end
                // system full step, gain coefficient at its end
                ST_SYS_FS: begin
                    if (step_end) begin
                        s_next.fcoef = modulator_code;
                        s_next.mode  = MODE_NORMAL;
                        s_next.fsm   = ST_POST;
                        ev[STAT_CAL_POS] = 1'b1;
                    end
                end
                // self zero half, then switch to the reference
                ST_SELF_ZS: begin
                    if (step_end) begin
                        s_next.zcoef = modulator_code;
                        s_next.steps = 2'h0;
                        s_next.sel   = SEL_REF;
                        s_next.fsm   = ST_SELF_FS;
                    end
                end
                // self full half, back to the external input
                ST_SELF_FS: begin
                    if (step_end) begin
                        s_next.fcoef = modulator_code;
                        s_next.mode  = MODE_NORMAL;
                        s_next.sel   = SEL_EXT;
                        s_next.fsm   = ST_POST;
                        ev[STAT_CAL_POS] = 1'b1;
                    end
                end
                // one normal conversion before ready falls
                ST_POST: begin
                    if (per_tick) begin
                        s_next.data  = result;
                        s_next.rdy_n = 1'b0;
                        s_next.raise_pend = 1'b0;
                        s_next.fsm   = ST_IDLE;
                        ev[STAT_DATA_POS] = 1'b1;
                    end
                end
                // unused codes fall back to normal mode
                default: begin
                    s_next.fsm = ST_IDLE;
                end
            endcase
        end

        // ready stays high while a step runs and no raise is pending
        if (s_reg.fsm != ST_IDLE && s_reg.fsm != ST_POST && !s_reg.raise_pend) begin
            s_next.rdy_n = 1'b1;
        end
        // a ready line that was low rises at the next modulator tick
        if (s_reg.raise_pend && mod_tick && s_reg.fsm != ST_IDLE) begin
            s_next.rdy_n = 1'b1;
            s_next.raise_pend = 1'b0;
        end
        // a ready line that was high stays high from the command on
        if (cal_cmd && s_reg.rdy_n) begin
            s_next.rdy_n = 1'b1;
        end

        // sticky status, read clears, a new event wins
        if (rd && mapped && addr == ADDR_STAT) begin
            s_next.stat = ev;
        end else begin
            s_next.stat = s_reg.stat | ev;
        end
        s_next.irq = |(s_next.stat & s_next.mask);
    end

    // ==========================================================
    // registers, defaults on reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // every other field clears to zero
            s_reg            <= '0;
            s_reg.rate       <= RATE_RST;
            s_reg.zcoef      <= ZCOEF_RST[DATA_W-1:0];
            s_reg.fcoef      <= FCOEF_RST[DATA_W-1:0];
            s_reg.fsm        <= ST_IDLE;
            s_reg.rdy_n      <= 1'b1;
            s_reg.sel        <= SEL_EXT;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs straight from flip-flops
    assign pready                = s_reg.pready;
    assign prdata                = s_reg.prdata;
    assign pslverr               = s_reg.pslverr;
    assign analog_input_pair_sel = s_reg.sel;
    assign conversion_ready_low  = s_reg.rdy_n;
    assign irq                   = s_reg.irq;

endmodule : adcsc_top

// file: verif/adcsc_top_sva.sv
// assertion checker for the calibration sequencer ports
`timescale 1ns/1ps
module adcsc_top_sva
    import adcsc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic [1:0]  analog_input_pair_sel,
    input wire logic        conversion_ready_low
);
    // ==========================================================
    // helper: programmed period, age of the last setup write, system step active
    logic [15:0] rate_q;
    logic [19:0] cnt_q;
    logic        act_q;
    logic [1:0]  mode_q;
    logic        wr_set;
    logic        rd_set;
    int          per;
    assign wr_set = psel && penable && pready && pwrite && paddr == {24'h0, ADDR_SETUP};
    assign rd_set = pready && !pwrite && paddr == {24'h0, ADDR_SETUP};
    assign per    = (rate_q == 16'h0) ? 1 : int'(rate_q);
    // track what the host has programmed and how long ago the command came
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rate_q <= RATE_RST;
            cnt_q  <= 20'h0;
            act_q  <= 1'b0;
            mode_q <= MODE_NORMAL;
        end else begin
            if (psel && penable && pready && pwrite && paddr == {24'h0, ADDR_RATE}) begin
                rate_q <= pwdata[15:0];
            end
            cnt_q <= wr_set ? 20'h0 : cnt_q + 20'h1;
            if (wr_set) begin
                act_q  <= pwdata[SETUP_HI_POS];
                mode_q <= pwdata[1:0];
            end else if (cnt_q > 20'd130 && !conversion_ready_low) begin
                act_q <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ==========================================================
    // properties
    AST_RESET_IDLE: assert property (
        $fell(reset) |-> conversion_ready_low && !pready && analog_input_pair_sel == SEL_EXT)
        else $error("outputs not idle after reset");
    AST_RDY_RAISE: assert property (
        wr_set && pwdata[1:0] != MODE_NORMAL && rate_q > 16'd40 |-> ##[1:129] conversion_ready_low)
        else $error("ready not raised within one modulator cycle");
    AST_RDY_HOLD: assert property (
        act_q && cnt_q > 20'd130 && cnt_q < 4 * per - 1 |-> conversion_ready_low)
        else $error("ready fell during calibration");
    AST_RDY_FALL: assert property (
        act_q && $fell(conversion_ready_low) && cnt_q > 20'd130 |-> cnt_q >= 4 * per && cnt_q <= 4 * per + 1)
        else $error("ready fell at the wrong time");
    AST_RDY_LATE: assert property (
        act_q |-> cnt_q <= 4 * per + 1)
        else $error("ready still high after four periods");
    AST_MODE_BUSY: assert property (
        rd_set && act_q && cnt_q > 20'd3 && cnt_q < 3 * per - 2 |-> prdata[1:0] == mode_q)
        else $error("mode field lost during step");
    AST_MODE_CLEAR: assert property (
        rd_set && act_q && cnt_q > 3 * per + 1 |-> prdata[1:0] == MODE_NORMAL)
        else $error("mode field not cleared after three periods");
    AST_SEL_EXT: assert property (
        act_q && cnt_q > 20'd1 |-> analog_input_pair_sel == SEL_EXT)
        else $error("system step not on external input");
    AST_SEL_SELF: assert property (
        wr_set && pwdata[1:0] == MODE_SELF |-> ##[1:2] analog_input_pair_sel == SEL_SHORT)
        else $error("self step not on shorted input");
endmodule : adcsc_top_sva
bind adcsc_top adcsc_top_sva adcsc_top_sva_inst (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .analog_input_pair_sel(analog_input_pair_sel),
    .conversion_ready_low(conversion_ready_low)
);

// file: verif/adcsc_host.sv
// apb host model that issues register transfers to the sequencer
`timescale 1ns/1ps
module adcsc_host (
    input  wire logic        ref_clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata
);
    // bus idle from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 32'h0;
        pwdata  = 32'h0;
    end
    // setup then access, request held until pready is sampled high or 16 cycles pass
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {24'h0, addr};
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd  = prdata;
        err = pslverr;
        ok  = (n < 16);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : adcsc_host

// file: verif/test_adc_system_calibration_sequencer.sv
// self-checking bench for the calibration sequencer
`timescale 1ns/1ps
module test_adc_system_calibration_sequencer;
    import adcsc_pkg::*;
    localparam int R = 64; // programmed output period in clocks
    logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, conversion_ready_low, irq, err, ok;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] modulator_code;
    logic [1:0]  analog_input_pair_sel;
    int          n_errors = 0, checks_done = 0, cyc = 0;
    // ==========================================================
    // clock, cycle count, instances
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;
    adcsc_top adcsc_top_inst (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .modulator_code(modulator_code), .analog_input_pair_sel(analog_input_pair_sel),
        .conversion_ready_low(conversion_ready_low), .irq(irq));
    adcsc_host adcsc_host_inst (
        .ref_clk(ref_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // ==========================================================
    // comparisons and bus helpers
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        adcsc_host_inst.xfer(1'b1, a, d, rd, err, ok);
        chk_bit(ok, 1'b1);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        adcsc_host_inst.xfer(1'b0, a, 32'h0, rd, err, ok);
        chk_word(rd, exp);
    endtask : rd_chk
    task automatic wait_low();
        for (int i = 0; i < 8192 && conversion_ready_low !== 1'b0; i++) @(posedge ref_clk);
    endtask : wait_low
    // one command, timed from its write edge to the fall of ready
    task automatic do_cal(input logic [2:0] sv, input logic [15:0] c1, input logic [15:0] c2,
                          input logic [1:0] s1, input logic [1:0] s2, input int np);
        int e;
        int n;
        int k;
        modulator_code <= c1;
        wait_low();
        wr(ADDR_SETUP, {29'h0, sv});
        e = cyc;
        n = 0;
        k = 0;
        while (k == 0 && n < np * R + 8) begin
            @(posedge ref_clk);
            n = cyc - e;
            if (n == 129) chk_bit(conversion_ready_low, 1'b1);
            if (n == R) rd_chk(ADDR_SETUP, {29'h0, sv});
            if (n == R + 8) chk_word({30'h0, analog_input_pair_sel}, {30'h0, s1});
            if (n == 3 * R + 2) modulator_code <= c2;
            if (n == 3 * R + 8) chk_word({30'h0, analog_input_pair_sel}, {30'h0, s2});
            if (n == 3 * R + 16) rd_chk(ADDR_SETUP, {29'h0, sv[2], (np == 4) ? 2'h0 : sv[1:0]});
            if (n > 129 && conversion_ready_low === 1'b0) k = n;
        end
        chk_bit(k >= np * R && k <= np * R + 1, 1'b1);
        chk_bit(irq, 1'b1);
        rd_chk(ADDR_STAT, 32'h3);
        repeat (2) @(posedge ref_clk);
        chk_bit(irq, 1'b0);
    endtask : do_cal
    // ==========================================================
    // scenarios
    task automatic test_reset();
        logic [7:0]  a [6] = '{ADDR_SETUP, ADDR_RATE, ADDR_ZCOEF, ADDR_FCOEF, ADDR_STAT, ADDR_MASK};
        logic [15:0] v [6] = '{16'h0, RATE_RST, ZCOEF_RST, FCOEF_RST, 16'h0, 16'h0};
        chk_bit(conversion_ready_low, 1'b1);
        for (int i = 0; i < 6; i++) rd_chk(a[i], {16'h0, v[i]});
        adcsc_host_inst.xfer(1'b0, 8'h1c, 32'h0, rd, err, ok);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_sys_zero();
        wr(ADDR_RATE, 32'(R));
        wr(ADDR_MASK, 32'h0);
        wait_low();
        chk_bit(irq, 1'b0);
        wr(ADDR_MASK, 32'h3);
        repeat (2) @(posedge ref_clk);
        chk_bit(irq, 1'b1);
        do_cal(3'h2, 16'h0123, 16'h0123, SEL_EXT, SEL_EXT, 4);
        rd_chk(ADDR_ZCOEF, 32'h0123);
        rd_chk(ADDR_FCOEF, 32'hffff);
        rd_chk(ADDR_DATA, 32'h0);
        $display("test_sys_zero done");
    endtask : test_sys_zero
    task automatic test_sys_full();
        do_cal(3'h7, 16'h0f00, 16'h0f00, SEL_EXT, SEL_EXT, 4);
        rd_chk(ADDR_FCOEF, 32'h0f00);
        rd_chk(ADDR_ZCOEF, 32'h0123);
        rd_chk(ADDR_DATA, 32'h8ddd);
        $display("test_sys_full done");
    endtask : test_sys_full
    task automatic test_lone_zero();
        do_cal(3'h6, 16'h0200, 16'h0200, SEL_EXT, SEL_EXT, 4);
        rd_chk(ADDR_ZCOEF, 32'h0200);
        rd_chk(ADDR_FCOEF, 32'h0f00);
        rd_chk(ADDR_DATA, 32'h8000);
        $display("test_lone_zero done");
    endtask : test_lone_zero
    task automatic test_self();
        do_cal(3'h1, 16'h0011, 16'h0022, SEL_SHORT, SEL_REF, 7);
        rd_chk(ADDR_ZCOEF, 32'h0011);
        rd_chk(ADDR_FCOEF, 32'h0022);
        rd_chk(ADDR_DATA, 32'h0011);
        $display("test_self done");
    endtask : test_self
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        reset = 1'b1;
        modulator_code = 16'h0;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        test_reset();
        test_sys_zero();
        test_sys_full();
        test_lone_zero();
        test_self();
        give_verdict();
    end
    // watchdog well beyond the expected run of about 1500 cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end
endmodule : test_adc_system_calibration_sequencer
